//--- include/efm_pkg.sv
// package: constants and types for the event flag and merge unit
package efm_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NTHR   = 6;   // event processor threads
  localparam int NSEL   = 12;  // merge select bits per channel
  localparam int NCH    = 3;   // output controller channels served
  localparam int ADDR_W = 18;  // avalon byte address width
  localparam int DATA_W = 32;  // avalon data width
  localparam int BE_W   = 4;   // avalon byte enables
  localparam int IDX_W  = 16;  // register index width

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 16'he300;
  localparam logic [IDX_W-1:0] IDX_FLAGS      = 16'he308;
  localparam logic [IDX_W-1:0] IDX_MG0_LO     = 16'he310;
  localparam logic [IDX_W-1:0] IDX_MG0_HI     = 16'he311;
  localparam logic [IDX_W-1:0] IDX_MG1_LO     = 16'he312;
  localparam logic [IDX_W-1:0] IDX_MG1_HI     = 16'he313;
  localparam logic [IDX_W-1:0] IDX_MG2_LO     = 16'he314;
  localparam logic [IDX_W-1:0] IDX_MG2_HI     = 16'he315;

  // ---------------------------------------------------------------
  // field layout, reset and response codes
  // ---------------------------------------------------------------
  localparam int LO_W   = 8;   // lower merge register: select bits 7..0
  localparam int HI_W   = 4;   // upper merge register: select bits 11..8
  localparam int HI_LSB = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NTHR-1:0] ev14;  // flag set events
    logic [NTHR-1:0] ev11;  // merge source events 11
    logic [NTHR-1:0] ev10;  // merge source events 10
  } efm_ev_type;

  typedef enum logic [1:0] {BUS_IDLE = 2'h0, BUS_ACK = 2'h1} efm_bus_type;

  typedef enum logic [3:0] {
    REG_NONE, REG_EN, REG_FLAG, REG_M0L, REG_M0H, REG_M1L, REG_M1H, REG_M2L, REG_M2H
  } efm_reg_type;

  typedef struct packed {
    efm_bus_type                bus_st;
    logic                       waitreq;
    logic [DATA_W-1:0]          rdata;
    logic [1:0]                 resp;
    logic [NTHR-1:0]            flags;
    logic [NTHR-1:0]            enable;
    logic [NCH-1:0][NSEL-1:0]   sel;
    logic                       irq;
  } efm_state_type;

  localparam efm_state_type ST_RESET = '{bus_st: BUS_IDLE, waitreq: 1'b1, default: '0};

endpackage

//--- src/efm_top.sv
// module: thread event flags, interrupt and event merge for output channels
`timescale 1ns/10ps

// Overview of operation
// - six thread flags in bits 5..0, set by that thread's event 14
// - a flag reads 1 once its source occurred, 0 otherwise
// - writing 1 clears a flag, writing 0 leaves it alone
// - a clear in the same cycle as a new event wins; set ignored
// - interrupt raised while any flag and its enable are both 1
// - reserved bits read 0; software writes 0 to them
// - merge select 1 includes its event in the OR, 0 excludes it
// - lower channel 0 bits 0..7: ev10, ev11 of threads 0 to 3
// - upper channel 0 bits 0..3: ev10, ev11 of threads 4 and 5
// - second register pair, same mapping, feeds channel 1
// - third register pair, same mapping, feeds channel 2
// - each channel input is the OR of its enabled thread events
// - separate enable register gates each flag onto the interrupt
// - merged result is delivered as the channel's event input

module efm_top
(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_srst,
  input  wire logic [efm_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [efm_pkg::DATA_W-1:0] i_avs_writedata,
  input  wire logic [efm_pkg::BE_W-1:0]   i_avs_byteenable,
  output logic      [efm_pkg::DATA_W-1:0] o_avs_readdata,
  output logic                            o_avs_waitrequest,
  output logic      [1:0]                 o_avs_response,
  input  wire efm_pkg::efm_ev_type        i_thread_ev,
  output logic      [efm_pkg::NCH-1:0]    o_poc_ev,
  output logic                            o_irq
);
  import efm_pkg::*;

  // ---------------------------------------------------------------
  // state and helpers
  // ---------------------------------------------------------------
  efm_state_type   st_r;
  efm_state_type   st_nxt;
  efm_reg_type     hit;
  logic            wr_lane;
  logic [NTHR-1:0] clr_mask;
  logic [NTHR-1:0] set_mask;
  logic [NSEL-1:0] src_vec;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // address to register decode, low two bits are the byte lane
  function automatic efm_reg_type reg_decode(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    case (idx)
      IDX_IRQ_ENABLE: reg_decode = REG_EN;
      IDX_FLAGS:      reg_decode = REG_FLAG;
      IDX_MG0_LO:     reg_decode = REG_M0L;
      IDX_MG0_HI:     reg_decode = REG_M0H;
      IDX_MG1_LO:     reg_decode = REG_M1L;
      IDX_MG1_HI:     reg_decode = REG_M1H;
      IDX_MG2_LO:     reg_decode = REG_M2L;
      IDX_MG2_HI:     reg_decode = REG_M2H;
      default:        reg_decode = REG_NONE;
    endcase
  endfunction

  // interleave events: bit 2t is ev10 of thread t, bit 2t+1 its ev11
  function automatic logic [NSEL-1:0] ev_pair(input logic [NTHR-1:0] e10,
                                              input logic [NTHR-1:0] e11);
    logic [NSEL-1:0] r;
    r = '0;
    for (int t = 0; t < NTHR; t++)
    begin
      r[2*t]   = e10[t];
      r[2*t+1] = e11[t];
    end
    return r;
  endfunction

  // read mux, unused upper bits stay zero
  function automatic logic [DATA_W-1:0] reg_read(input efm_reg_type k,
                                                 input efm_state_type s);
    logic [DATA_W-1:0] r;
    r = '0;
    case (k)
      REG_EN:   r = DATA_W'(s.enable);
      REG_FLAG: r = DATA_W'(s.flags);
      REG_M0L:  r = DATA_W'(s.sel[0][LO_W-1:0]);
      REG_M0H:  r = DATA_W'(s.sel[0][NSEL-1:HI_LSB]);
      REG_M1L:  r = DATA_W'(s.sel[1][LO_W-1:0]);
      REG_M1H:  r = DATA_W'(s.sel[1][NSEL-1:HI_LSB]);
      REG_M2L:  r = DATA_W'(s.sel[2][LO_W-1:0]);
      REG_M2H:  r = DATA_W'(s.sel[2][NSEL-1:HI_LSB]);
      default:  r = '0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------

  // bus decode, flag update, register writes and bus handshake
  always_comb
  begin
    st_nxt   = st_r;
    hit      = reg_decode(i_avs_address);
    // a write takes effect only on the edge where waitrequest is low
    wr_lane  = (st_r.bus_st == BUS_ACK) && i_avs_write && i_avs_byteenable[0];
    clr_mask = (wr_lane && hit == REG_FLAG) ? i_avs_writedata[NTHR-1:0] : '0;
    set_mask = i_thread_ev.ev14 & ~clr_mask;
    // sticky flags: clear has priority over a new event
    st_nxt.flags = (st_r.flags | set_mask) & ~clr_mask;

    // control register writes, reserved bits dropped
    if (wr_lane)
    begin
      case (hit)
        REG_EN:  st_nxt.enable = i_avs_writedata[NTHR-1:0];
        REG_M0L: st_nxt.sel[0][LO_W-1:0] = i_avs_writedata[LO_W-1:0];
        REG_M0H: st_nxt.sel[0][NSEL-1:HI_LSB] = i_avs_writedata[HI_W-1:0];
        REG_M1L: st_nxt.sel[1][LO_W-1:0] = i_avs_writedata[LO_W-1:0];
        REG_M1H: st_nxt.sel[1][NSEL-1:HI_LSB] = i_avs_writedata[HI_W-1:0];
        REG_M2L: st_nxt.sel[2][LO_W-1:0] = i_avs_writedata[LO_W-1:0];
        REG_M2H: st_nxt.sel[2][NSEL-1:HI_LSB] = i_avs_writedata[HI_W-1:0];
        default: st_nxt.enable = st_r.enable;
      endcase
    end

    // slave handshake: one wait cycle, then answer for one cycle
    case (st_r.bus_st)
      BUS_IDLE:
      begin
        if (i_avs_read || i_avs_write)
        begin
          st_nxt.bus_st  = BUS_ACK;
          st_nxt.waitreq = 1'b0;
          st_nxt.resp    = (hit == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
          if (i_avs_read)
          begin
            st_nxt.rdata = reg_read(hit, st_r);
          end
        end
      end
      BUS_ACK:
      begin
        st_nxt.bus_st  = BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
      default:
      begin
        st_nxt.bus_st  = BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase

    // interrupt level from the flags and enables about to be stored
    st_nxt.irq = |(st_nxt.flags & st_nxt.enable);
  end

  // state register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      st_r <= ST_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // bus and interrupt outputs straight from the state register
  assign o_avs_readdata    = st_r.rdata;
  assign o_avs_waitrequest = st_r.waitreq;
  assign o_avs_response    = st_r.resp;
  assign o_irq             = st_r.irq;

  // merge: or of selected thread events, no latching stage
  always_comb
  begin
    src_vec = ev_pair(i_thread_ev.ev10, i_thread_ev.ev11);
    for (int c = 0; c < NCH; c++)
    begin
      o_poc_ev[c] = |(st_r.sel[c] & src_vec);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  // flag set by event 14 unless cleared in the same cycle
  a_flag_set_event: assert property (
    (set_mask != '0) |=> ((st_r.flags & $past(set_mask)) == $past(set_mask)))
    else $error("flag not set by thread event");

  // a flag only rises after its event
  a_flag_rise_cause: assert property (
    1'b1 |=> ((st_r.flags & ~$past(st_r.flags) & ~$past(i_thread_ev.ev14)) == '0))
    else $error("flag rose without its event");

  // write one clears the written flags, write zero keeps others
  a_flag_w1c_clear: assert property (
    (clr_mask != '0) |=>
      ((st_r.flags & $past(clr_mask)) == '0) &&
      ((st_r.flags & ~$past(clr_mask)) ==
       (($past(st_r.flags) | $past(i_thread_ev.ev14)) & ~$past(clr_mask))))
    else $error("flag write one clear wrong");

  // clear beats a same-cycle set
  a_clear_beats_set: assert property (
    ((clr_mask & i_thread_ev.ev14) != '0) |=>
      ((st_r.flags & $past(clr_mask & i_thread_ev.ev14)) == '0))
    else $error("set won over clear");

  // interrupt level follows flags and enables
  a_irq_flag_enable: assert property (
    o_irq == |(st_r.flags & st_r.enable))
    else $error("interrupt level mismatch");

  // reserved read bits of the flag register are zero
  a_rsvd_read_zero: assert property (
    (!o_avs_waitrequest && $past(hit) == REG_FLAG && $past(i_avs_read)) |->
      (o_avs_readdata[DATA_W-1:NTHR] == '0))
    else $error("reserved flag bits read nonzero");

  // a selected event reaches channel 0
  a_merge_sel_on: assert property (
    (st_r.sel[0][0] && i_thread_ev.ev10[0]) |-> o_poc_ev[0])
    else $error("selected event missing on channel 0");

  // nothing selected gives a quiet channel 2
  a_merge_sel_off: assert property (
    (st_r.sel[2] == '0) |-> !o_poc_ev[2])
    else $error("channel 2 active with no select");

  // lower channel 0 write lands in select bits 7..0
  a_merge_lo_write: assert property (
    (wr_lane && hit == REG_M0L) |=> (st_r.sel[0][LO_W-1:0] == $past(i_avs_writedata[LO_W-1:0])))
    else $error("channel 0 lower select not written");

  // upper channel 1 write lands in select bits 11..8
  a_merge_hi_write: assert property (
    (wr_lane && hit == REG_M1H) |=>
      (st_r.sel[1][NSEL-1:HI_LSB] == $past(i_avs_writedata[HI_W-1:0])))
    else $error("channel 1 upper select not written");

  // thread 5 event 11 maps to select bit 11 of channel 2
  a_merge_top_bit: assert property (
    (st_r.sel[2] == 12'h800 && i_thread_ev.ev11[5]) |-> o_poc_ev[2])
    else $error("channel 2 top bit mapping wrong");

  // request answered with waitrequest low exactly one cycle later
  a_bus_answer_time: assert property (
    (st_r.bus_st == BUS_IDLE && (i_avs_read || i_avs_write)) |=>
      !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  // no event and no clear leaves the flags alone
  a_flag_hold_idle: assert property (
    ((clr_mask == '0) && (i_thread_ev.ev14 == '0)) |=>
      $stable(st_r.flags))
    else $error("flags changed without cause");

  // writing zero to the flag register keeps every flag
  a_flag_write_zero: assert property (
    (wr_lane && hit == REG_FLAG && i_avs_writedata[NTHR-1:0] == '0) |=>
      (st_r.flags == ($past(st_r.flags) | $past(i_thread_ev.ev14))))
    else $error("zero write changed flags");

  // upper merge reads return zero in reserved bits 7..4
  a_rsvd_hi_zero: assert property (
    (!o_avs_waitrequest && $past(i_avs_read) && ($past(hit) inside {REG_M0H, REG_M1H, REG_M2H}))
      |-> (o_avs_readdata[DATA_W-1:HI_W] == '0))
    else $error("reserved merge bits read nonzero");

  // every register is at most eight bits wide
  a_rsvd_lo_zero: assert property (
    (!o_avs_waitrequest && $past(i_avs_read)) |->
      (o_avs_readdata[DATA_W-1:LO_W] == '0))
    else $error("read data above bit 7 nonzero");

  // no enable bit, no interrupt
  a_irq_needs_enable: assert property (
    (st_r.enable == '0) |->
      !o_irq)
    else $error("interrupt without enable");

  // an enabled event raises the interrupt on the next edge
  a_irq_event_rise: assert property (
    (((set_mask & st_r.enable) != '0) && !(wr_lane && hit == REG_EN)) |=>
      o_irq)
    else $error("enabled event gave no interrupt");

  // select bit 8 of channel 0 carries event 10 of thread 4
  a_merge_ch0_hi: assert property (
    (st_r.sel[0][HI_LSB] && i_thread_ev.ev10[4]) |->
      o_poc_ev[0])
    else $error("channel 0 upper mapping wrong");

  // select bit 5 of channel 1 carries event 11 of thread 2
  a_merge_ch1_map: assert property (
    (st_r.sel[1][5] && i_thread_ev.ev11[2]) |->
      o_poc_ev[1])
    else $error("channel 1 mapping wrong");

  // select bit 6 of channel 2 carries event 10 of thread 3
  a_merge_ch2_lo: assert property (
    (st_r.sel[2][6] && i_thread_ev.ev10[3]) |->
      o_poc_ev[2])
    else $error("channel 2 lower mapping wrong");

  // no merge source active, all channels quiet
  a_merge_no_event: assert property (
    ((i_thread_ev.ev10 == '0) && (i_thread_ev.ev11 == '0)) |->
      (o_poc_ev == '0))
    else $error("channel active with no event");

  // a cleared select bit keeps its event out of the or
  a_merge_mask_off: assert property (
    (!st_r.sel[0][0] && i_thread_ev.ev10 == 6'h01 && i_thread_ev.ev11 == '0) |->
      !o_poc_ev[0])
    else $error("unselected event reached channel 0");

  // merged outputs move only with selects or events
  a_merge_follow_in: assert property (
    ($stable(st_r.sel) && $stable(i_thread_ev)) |->
      $stable(o_poc_ev))
    else $error("channel output changed on its own");

  // enable register write lands in bits 5..0
  a_enable_write: assert property (
    (wr_lane && hit == REG_EN) |=>
      (st_r.enable == $past(i_avs_writedata[NTHR-1:0])))
    else $error("enable register not written");

  // upper channel 2 write lands in select bits 11..8
  a_merge_ch2_hi: assert property (
    (wr_lane && hit == REG_M2H) |=>
      (st_r.sel[2][NSEL-1:HI_LSB] == $past(i_avs_writedata[HI_W-1:0])))
    else $error("channel 2 upper select not written");

  // unmapped index answers with an error and zero data
  a_bus_slverr: assert property (
    (st_r.bus_st == BUS_IDLE && (i_avs_read || i_avs_write) && hit == REG_NONE) |=>
      (o_avs_response == RESP_SLVERR) && (!$past(i_avs_read) || o_avs_readdata == '0))
    else $error("unmapped access not refused");

  // waitrequest stays high while the bus is idle
  a_bus_idle_wait: assert property (
    (st_r.bus_st == BUS_IDLE && !i_avs_read && !i_avs_write) |=>
      o_avs_waitrequest)
    else $error("waitrequest dropped without request");

  // main scenarios
  c_flag_set:    cover property (set_mask != '0);
  c_clear_clash: cover property ((clr_mask & i_thread_ev.ev14) != '0);
  c_irq_rise:    cover property ($rose(o_irq));
  c_merge_out:   cover property (o_poc_ev != '0);
  c_bus_error:   cover property (o_avs_response == RESP_SLVERR);

endmodule

//--- test/efm_thread_model.sv
// partner model: event processor threads feeding the unit
`timescale 1ns/10ps
module efm_thread_model
(
  input  wire logic                i_ref_clk,
  input  wire efm_pkg::efm_ev_type i_req,
  output efm_pkg::efm_ev_type      o_ev
);
  import efm_pkg::*;
  // threads emit the requested events on the clock, one cycle later
  always_ff @(posedge i_ref_clk)
  begin
    o_ev <= i_req;
  end
endmodule

//--- test/testbench.sv
// testbench: registers, flags, interrupt and event merge of the unit
`timescale 1ns/10ps
module testbench;
  import efm_pkg::*;
  logic              ref_clk;
  logic              srst;
  logic [ADDR_W-1:0] address;
  logic              rd;
  logic              wr;
  logic [DATA_W-1:0] wdata;
  logic [BE_W-1:0]   be;
  logic [DATA_W-1:0] rdata;
  logic              waitreq;
  logic [1:0]        resp;
  efm_ev_type        ev_req;
  efm_ev_type        ev;
  logic [NCH-1:0]    poc_ev;
  logic              irq;
  int                fails;
  int                compares;
  int                cycles;
  logic [31:0]       d;
  logic [1:0]        r;
  localparam logic [15:0] REGS [8] = '{IDX_IRQ_ENABLE, IDX_FLAGS, IDX_MG0_LO, IDX_MG0_HI,
                                       IDX_MG1_LO, IDX_MG1_HI, IDX_MG2_LO, IDX_MG2_HI};

  efm_top uut (.i_ref_clk(ref_clk), .i_srst(srst), .i_avs_address(address), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_avs_response(resp),
    .i_thread_ev(ev), .o_poc_ev(poc_ev), .o_irq(irq));
  efm_thread_model thr (.i_ref_clk(ref_clk), .i_req(ev_req), .o_ev(ev));

  // ---------------------------------------------------------------
  // bus cycles and comparison
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access held until waitrequest is sampled low
  task bus(input logic w, input logic [15:0] idx, input logic [7:0] v);
    @(posedge ref_clk);
    address <= {idx, 2'h0};
    wdata   <= {24'h0, v};
    be      <= 4'h1;
    wr      <= w;
    rd      <= ~w;
    do @(posedge ref_clk); while (waitreq !== 1'b0);
    d = rdata;
    r = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task pulse(input logic [5:0] f);
    @(posedge ref_clk);
    ev_req.ev14 <= f;
    @(posedge ref_clk);
    ev_req.ev14 <= 6'h0;
  endtask

  task end_sim;
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, REGS[i], 8'h0);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
    end
    bus(1'b0, 16'h1234, 8'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
  endtask

  task t_flags;
    pulse(6'h3f);
    bus(1'b0, IDX_FLAGS, 8'h0);
    chk(d, 32'h3f);
    bus(1'b1, IDX_FLAGS, 8'h05);
    bus(1'b0, IDX_FLAGS, 8'h0);
    chk(d, 32'h3a);
    bus(1'b1, IDX_FLAGS, 8'h00);
    bus(1'b0, IDX_FLAGS, 8'h0);
    chk(d, 32'h3a);
    bus(1'b1, IDX_FLAGS, 8'h3a);
  endtask

  task t_irq;
    bus(1'b1, IDX_IRQ_ENABLE, 8'h02);
    pulse(6'h10);
    settle;
    chk({31'h0, irq}, 32'h0);
    pulse(6'h02);
    settle;
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h00);
    settle;
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h02);
    settle;
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, IDX_FLAGS, 8'h12);
    settle;
    chk({31'h0, irq}, 32'h0);
  endtask

  // clear of thread 0 lands on the same edge as a new thread 0 event
  task t_collide;
    pulse(6'h01);
    @(posedge ref_clk);
    address     <= {IDX_FLAGS, 2'h0};
    wdata       <= 32'h1;
    be          <= 4'h1;
    wr          <= 1'b1;
    ev_req.ev14 <= 6'h01;
    @(posedge ref_clk);
    ev_req.ev14 <= 6'h0;
    while (waitreq !== 1'b0) @(posedge ref_clk);
    wr <= 1'b0;
    bus(1'b0, IDX_FLAGS, 8'h0);
    chk(d, 32'h0);
  endtask

  task t_merge;
    logic [15:0] lo;
    logic [11:0] s;
    efm_ev_type  e;
    for (int c = 0; c < NCH; c++)
    begin
      lo = IDX_MG0_LO + 16'(2 * c);
      for (int b = 0; b < NSEL; b++)
      begin
        s = 12'h1 << b;
        e = '0;
        if (b % 2 == 0) e.ev10[b / 2] = 1'b1;
        else e.ev11[b / 2] = 1'b1;
        bus(1'b1, lo, s[7:0]);
        bus(1'b1, lo + 16'h1, {4'h0, s[11:8]});
        bus(1'b0, lo + 16'h1, 8'h0);
        chk(d, {28'h0, s[11:8]});
        @(posedge ref_clk);
        ev_req <= e;
        @(posedge ref_clk);
        #1;
        chk({29'h0, poc_ev}, 32'h1 << c);
        @(posedge ref_clk);
        ev_req <= {6'h0, ~e[11:0]};
        settle;
        chk({29'h0, poc_ev}, 32'h0);
        @(posedge ref_clk);
        ev_req <= '0;
      end
      bus(1'b1, lo + 16'h1, 8'h0);
    end
  endtask

  // reset in mid-run returns registers and the interrupt to zero
  task t_midrst;
    bus(1'b1, IDX_IRQ_ENABLE, 8'h3f);
    bus(1'b1, IDX_MG1_LO, 8'hff);
    pulse(6'h3f);
    settle;
    chk({31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, REGS[i], 8'h0);
      chk(d, 32'h0);
    end
    settle;
    chk({31'h0, irq}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      fails = fails + 1;
      end_sim;
    end
  end

  initial
  begin
    fails = 0;
    compares = 0;
    cycles = 0;
    srst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    address = '0;
    wdata = '0;
    be = '0;
    ev_req = '0;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_flags;
    t_irq;
    t_collide;
    t_merge;
    t_midrst;
    end_sim;
  end
endmodule
